// ===== hw/rgs_pkg.sv
// constants, types and register map of the radio data group sequence scheduler
package rgs_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned GROUP_PERIOD_NS = 87719298;
	localparam int unsigned GROUP_PERIOD_CYC = GROUP_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned LIST_MAX = 24;
	localparam int unsigned UDG_DEPTH = 8;
	localparam logic [7:0] SHORT_TEXT_LIMIT = 8'h3C;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PI = 8'h04;
	localparam logic [7:0] OFS_LIST_DATA = 8'h08;
	localparam logic [7:0] OFS_LIST_CTRL = 8'h0C;
	localparam logic [7:0] OFS_LIST_STAT = 8'h10;
	localparam logic [7:0] OFS_UDG_CTRL = 8'h14;
	localparam logic [7:0] OFS_GRP_B = 8'h18;
	localparam logic [7:0] OFS_UDG_CD = 8'h1C;
	localparam logic [7:0] OFS_PROTO_CD = 8'h20;
	localparam logic [7:0] OFS_DIRECT_CD = 8'h24;
	localparam logic [7:0] OFS_TAG = 8'h28;
	localparam logic [7:0] OFS_TAG_RUN = 8'h2C;
	localparam logic [7:0] OFS_PROGRAM = 8'h30;
	localparam logic [7:0] OFS_STORE = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_RT_LEN = 8'h3C;
	// reset values
	localparam logic [4:0] RST_CTRL = 5'h0F;
	localparam logic [15:0] RST_PI = 16'h0000;
	localparam logic [1:0] RST_PROGRAM = 2'h1;
	// symbol codes held in the list
	localparam logic [3:0] SYM_ZERO = 4'h0;
	localparam logic [3:0] SYM_ONE = 4'h1;
	localparam logic [3:0] SYM_TWO = 4'h2;
	localparam logic [3:0] SYM_PTYN = 4'h3;
	localparam logic [3:0] SYM_EON = 4'h4;
	localparam logic [3:0] SYM_USER1 = 4'h5;
	localparam logic [3:0] SYM_USER2 = 4'h6;
	localparam logic [3:0] SYM_TAG = 4'h7;
	localparam logic [3:0] SYM_PROTO = 4'h8;
	// default list 022E1022EA022XYR, element 0 first
	localparam logic [95:0] DEFAULT_LIST = 96'h00000000_76522034_22014220;
	localparam logic [4:0] DEFAULT_LEN = 5'h10;

	typedef enum logic [3:0] {
		SRC_0A = 4'h0, SRC_1A = 4'h1, SRC_2A = 4'h2, SRC_10A = 4'h3,
		SRC_14A = 4'h4, SRC_14B = 4'h5, SRC_USER1 = 4'h6, SRC_USER2 = 4'h7,
		SRC_3A = 4'h8, SRC_11A = 4'h9, SRC_PROTO = 4'hA, SRC_4A = 4'hB, SRC_DIRECT = 4'hC
	} rgs_src_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEEK = 2'b01
	} rgs_state_e;

	typedef struct packed {
		rgs_src_e src;
		logic [15:0] blk_a;
		logic [15:0] blk_b;
		logic [15:0] blk_c;
		logic [15:0] blk_d;
	} rgs_group_s;

	typedef struct packed {
		logic [4:0] type1;
		logic [4:0] start1;
		logic [4:0] len1;
		logic [4:0] type2;
		logic [4:0] start2;
		logic [3:0] len2;
	} rgs_tag_s;

	// ascii symbol to list code; bit 4 set when recognised
	function automatic logic [4:0] rgs_decode(input logic [7:0] ch);
		logic [4:0] r;
		r = 5'h00;
		case (ch)
			8'h30: r = {1'b1, SYM_ZERO};
			8'h31: r = {1'b1, SYM_ONE};
			8'h32: r = {1'b1, SYM_TWO};
			8'h41: r = {1'b1, SYM_PTYN};
			8'h45: r = {1'b1, SYM_EON};
			8'h58: r = {1'b1, SYM_USER1};
			8'h59: r = {1'b1, SYM_USER2};
			8'h52: r = {1'b1, SYM_TAG};
			8'h55: r = {1'b1, SYM_PROTO};
			default: r = 5'h00;
		endcase
		return r;
	endfunction : rgs_decode
endpackage : rgs_pkg

// ===== hw/rgs_scheduler.sv
// group sequence scheduler with apb register file
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
module rgs_scheduler #(
	parameter int unsigned GROUP_PERIOD = rgs_pkg::GROUP_PERIOD_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_program_sel,
	input wire logic ct_request,
	output rgs_pkg::rgs_group_s group_out,
	output logic group_valid,
	output logic tag_toggle,
	output logic tag_running,
	output logic [1:0] active_set,
	output logic nvm_load,
	output logic nvm_store,
	output logic [1:0] nvm_set,
	output logic rt_update,
	output logic rt_cr_insert
);
	logic [4:0] ctrl;
	logic [15:0] pi;
	logic [15:0] grp_b;
	logic [23:0][3:0] list;
	logic [23:0][3:0] stage;
	logic [4:0] list_len;
	logic [4:0] stage_len;
	logic stage_stop;
	logic stage_any;
	logic [4:0] ptr;
	logic [4:0] steps;
	logic [1:0] zero_rep;
	logic phase_r;
	logic phase_e;
	rgs_pkg::rgs_state_e state;
	logic [31:0] tick_cnt;
	logic tick;
	logic proto_pend;
	logic direct_pend;
	logic [47:0] proto_grp;
	logic [47:0] direct_grp;
	logic ct_pend;
	logic [2:0] ct_sync;
	logic [1:0] sw_sync;
	rgs_pkg::rgs_tag_s tag;
	logic tag_en;
	logic tag_run;
	logic [1:0] prog_sel;
	logic store_refused;
	logic [3:0] udg_cnt [2];
	logic [47:0] udg_head [2];
	logic u_listed;
	logic sym_ok;
	logic [3:0] sym_cur;
	logic [4:0] ptr_next;
	logic wr;
	logic rd_setup;
	logic mapped;
	logic emit;
	rgs_pkg::rgs_src_e emit_src;
	logic [4:0] dec;
	logic grp_sel;

	// apb: zero wait states, read data latched in the setup phase, write data in the access phase
	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign dec = rgs_pkg::rgs_decode(pwdata[7:0]);

	// address decode
	always_comb begin
		if (paddr == rgs_pkg::OFS_CTRL || paddr == rgs_pkg::OFS_PI || paddr == rgs_pkg::OFS_LIST_DATA) begin
			mapped = 1'b1;
		end else if (paddr == rgs_pkg::OFS_LIST_CTRL || paddr == rgs_pkg::OFS_LIST_STAT) begin
			mapped = 1'b1;
		end else if (paddr == rgs_pkg::OFS_UDG_CTRL || paddr == rgs_pkg::OFS_GRP_B || paddr == rgs_pkg::OFS_UDG_CD) begin
			mapped = 1'b1;
		end else if (paddr == rgs_pkg::OFS_PROTO_CD || paddr == rgs_pkg::OFS_DIRECT_CD) begin
			mapped = 1'b1;
		end else if (paddr == rgs_pkg::OFS_TAG || paddr == rgs_pkg::OFS_TAG_RUN || paddr == rgs_pkg::OFS_PROGRAM) begin
			mapped = 1'b1;
		end else if (paddr == rgs_pkg::OFS_STORE || paddr == rgs_pkg::OFS_STATUS || paddr == rgs_pkg::OFS_RT_LEN) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end
	assign pslverr = psel & penable & ~mapped;

	// read data, registered one cycle ahead of the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			if (paddr == rgs_pkg::OFS_CTRL) begin
				prdata <= {27'h0, ctrl};
			end else if (paddr == rgs_pkg::OFS_PI) begin
				prdata <= {16'h0, pi};
			end else if (paddr == rgs_pkg::OFS_LIST_STAT) begin
				prdata <= {19'h0, ptr, 3'h0, list_len};
			end else if (paddr == rgs_pkg::OFS_TAG) begin
				prdata <= {3'h0, tag};
			end else if (paddr == rgs_pkg::OFS_PROGRAM) begin
				prdata <= {28'h0, active_set, prog_sel};
			end else if (paddr == rgs_pkg::OFS_STATUS) begin
				prdata <= {17'h0, ct_pend, direct_pend, proto_pend, udg_cnt[1], udg_cnt[0],
					store_refused, tag_en, tag_running, tag_toggle};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// plain configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= rgs_pkg::RST_CTRL;
			pi <= rgs_pkg::RST_PI;
			grp_b <= 16'h0000;
		end else if (wr) begin
			if (paddr == rgs_pkg::OFS_CTRL) begin
				ctrl <= pwdata[4:0];
			end else if (paddr == rgs_pkg::OFS_PI) begin
				pi <= pwdata[15:0];
			end else if (paddr == rgs_pkg::OFS_GRP_B) begin
				grp_b <= pwdata[15:0];
			end
		end
	end

	// list staging: symbols arrive one per write, commit swaps them in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage <= '0;
			stage_len <= 5'h00;
			stage_stop <= 1'b0;
			stage_any <= 1'b0;
			list <= rgs_pkg::DEFAULT_LIST;
			list_len <= rgs_pkg::DEFAULT_LEN;
		end else if (wr && paddr == rgs_pkg::OFS_LIST_DATA) begin
			stage_any <= 1'b1;
			if (!dec[4]) begin
				stage_stop <= 1'b1;
			end else if (!stage_stop && stage_len < 5'(rgs_pkg::LIST_MAX)) begin
				stage[stage_len] <= dec[3:0];
				stage_len <= stage_len + 5'h01;
			end
		end else if (wr && paddr == rgs_pkg::OFS_LIST_CTRL) begin
			if (pwdata[1]) begin
				if (!stage_any) begin
					list <= rgs_pkg::DEFAULT_LIST;
					list_len <= rgs_pkg::DEFAULT_LEN;
				end else if (stage_len == 5'h00) begin
					list <= '0;
					list_len <= 5'h01;
				end else begin
					list <= stage;
					list_len <= stage_len;
				end
			end
			if (pwdata[0] || pwdata[1]) begin
				stage <= '0;
				stage_len <= 5'h00;
				stage_stop <= 1'b0;
				stage_any <= 1'b0;
			end
		end
	end

	// protocol buffer presence decides the fast path
	always_comb begin
		u_listed = 1'b0;
		for (int i = 0; i < 24; i++) begin
			if (5'(i) < list_len && list[i] == rgs_pkg::SYM_PROTO) begin
				u_listed = 1'b1;
			end
		end
	end

	// group period timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 32'h0000_0000;
		end else if (tick) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end
	assign tick = (tick_cnt == 32'(GROUP_PERIOD - 1));

	// symbol eligibility: absent services never reach here, disabled ones skip
	assign sym_cur = list[ptr];
	always_comb begin
		case (sym_cur)
			rgs_pkg::SYM_ZERO: sym_ok = 1'b1;
			rgs_pkg::SYM_ONE: sym_ok = ctrl[0];
			rgs_pkg::SYM_TWO: sym_ok = ctrl[1];
			rgs_pkg::SYM_PTYN: sym_ok = ctrl[2];
			rgs_pkg::SYM_EON: sym_ok = ctrl[3];
			rgs_pkg::SYM_USER1: sym_ok = (udg_cnt[0] != 4'h0);
			rgs_pkg::SYM_USER2: sym_ok = (udg_cnt[1] != 4'h0);
			rgs_pkg::SYM_TAG: sym_ok = tag_en;
			rgs_pkg::SYM_PROTO: sym_ok = proto_pend;
			default: sym_ok = 1'b0;
		endcase
	end
	assign ptr_next = (ptr + 5'h01 >= list_len) ? 5'h00 : ptr + 5'h01;

	// emission choice: injected and clock groups first, then the list
	always_comb begin
		emit = 1'b0;
		emit_src = rgs_pkg::SRC_0A;
		case (state)
			rgs_pkg::ST_IDLE: begin
				if (tick) begin
					if (direct_pend) begin
						emit = 1'b1;
						emit_src = rgs_pkg::SRC_DIRECT;
					end else if (ct_pend) begin
						emit = 1'b1;
						emit_src = rgs_pkg::SRC_4A;
					end else if (proto_pend && !u_listed) begin
						emit = 1'b1;
						emit_src = rgs_pkg::SRC_PROTO;
					end else if (zero_rep != 2'h0) begin
						emit = 1'b1;
						emit_src = rgs_pkg::SRC_0A;
					end
				end
			end
			rgs_pkg::ST_SEEK: begin
				if (steps >= list_len) begin
					emit = 1'b1;
					emit_src = rgs_pkg::SRC_0A;
				end else if (sym_ok) begin
					emit = 1'b1;
					case (sym_cur)
						rgs_pkg::SYM_ONE: emit_src = rgs_pkg::SRC_1A;
						rgs_pkg::SYM_TWO: emit_src = rgs_pkg::SRC_2A;
						rgs_pkg::SYM_PTYN: emit_src = rgs_pkg::SRC_10A;
						rgs_pkg::SYM_EON: emit_src = phase_e ? rgs_pkg::SRC_14B : rgs_pkg::SRC_14A;
						rgs_pkg::SYM_USER1: emit_src = rgs_pkg::SRC_USER1;
						rgs_pkg::SYM_USER2: emit_src = rgs_pkg::SRC_USER2;
						rgs_pkg::SYM_TAG: emit_src = phase_r ? rgs_pkg::SRC_11A : rgs_pkg::SRC_3A;
						rgs_pkg::SYM_PROTO: emit_src = rgs_pkg::SRC_PROTO;
						default: emit_src = rgs_pkg::SRC_0A;
					endcase
				end
			end
			default: emit = 1'b0;
		endcase
	end

	// list walker; a '0' symbol leaves three more 0A groups owed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= rgs_pkg::ST_IDLE;
			ptr <= 5'h00;
			steps <= 5'h00;
			zero_rep <= 2'h0;
			phase_r <= 1'b0;
			phase_e <= 1'b0;
		end else begin
			case (state)
				rgs_pkg::ST_IDLE: begin
					if (tick && !emit) begin
						state <= rgs_pkg::ST_SEEK;
						steps <= 5'h00;
					end else if (emit && emit_src == rgs_pkg::SRC_0A) begin
						zero_rep <= zero_rep - 2'h1;
					end
				end
				rgs_pkg::ST_SEEK: begin
					if (emit) begin
						state <= rgs_pkg::ST_IDLE;
					end else begin
						steps <= steps + 5'h01;
					end
					if (steps < list_len) begin
						ptr <= ptr_next;
					end
					if (emit && steps < list_len && sym_cur == rgs_pkg::SYM_ZERO) begin
						zero_rep <= 2'h3;
					end
					if (emit && steps < list_len && sym_cur == rgs_pkg::SYM_TAG) begin
						phase_r <= ~phase_r;
					end
					if (emit && steps < list_len && sym_cur == rgs_pkg::SYM_EON) begin
						phase_e <= ~phase_e;
					end
				end
				default: state <= rgs_pkg::ST_IDLE;
			endcase
			// a new list restarts at its head; a seek under way still ends in a group
			if (wr && paddr == rgs_pkg::OFS_LIST_CTRL && pwdata[1]) begin
				ptr <= 5'h00;
				zero_rep <= 2'h0;
			end
		end
	end

	// output group; block 1 always the programme code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_out <= '0;
			group_valid <= 1'b0;
		end else begin
			group_valid <= emit;
			if (emit) begin
				group_out.src <= emit_src;
				group_out.blk_a <= pi;
				case (emit_src)
					rgs_pkg::SRC_DIRECT: {group_out.blk_b, group_out.blk_c, group_out.blk_d} <= direct_grp;
					rgs_pkg::SRC_PROTO: {group_out.blk_b, group_out.blk_c, group_out.blk_d} <= proto_grp;
					rgs_pkg::SRC_USER1: {group_out.blk_b, group_out.blk_c, group_out.blk_d} <= udg_head[0];
					rgs_pkg::SRC_USER2: {group_out.blk_b, group_out.blk_c, group_out.blk_d} <= udg_head[1];
					default: {group_out.blk_b, group_out.blk_c, group_out.blk_d} <= 48'h0;
				endcase
			end
		end
	end

	// single-entry protocol and direct holders; a full holder refuses a push
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			proto_pend <= 1'b0;
			direct_pend <= 1'b0;
			proto_grp <= 48'h0;
			direct_grp <= 48'h0;
		end else begin
			if (emit && emit_src == rgs_pkg::SRC_PROTO) begin
				proto_pend <= 1'b0;
			end else if (wr && paddr == rgs_pkg::OFS_PROTO_CD && !proto_pend) begin
				proto_pend <= 1'b1;
				proto_grp <= {grp_b, pwdata};
			end
			if (emit && emit_src == rgs_pkg::SRC_DIRECT) begin
				direct_pend <= 1'b0;
			end else if (wr && paddr == rgs_pkg::OFS_DIRECT_CD && !direct_pend) begin
				direct_pend <= 1'b1;
				direct_grp <= {grp_b, pwdata};
			end
		end
	end

	// clock-time request pin: synchronise, then edge sets pending; set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ct_sync <= 3'h0;
			sw_sync <= 2'h3;
			ct_pend <= 1'b0;
		end else begin
			ct_sync <= {ct_sync[1:0], ct_request};
			sw_sync <= {sw_sync[0], ext_program_sel};
			if (ct_sync[1] && !ct_sync[2]) begin
				ct_pend <= 1'b1;
			end else if (emit && emit_src == rgs_pkg::SRC_4A) begin
				ct_pend <= 1'b0;
			end
		end
	end

	// user group buffers, one per generate pass
	for (genvar b = 0; b < 2; b++) begin : g_udg
		logic [47:0] mem [rgs_pkg::UDG_DEPTH];
		logic [3:0] cnt;
		logic [2:0] rd;
		logic sel_b;
		logic take;
		assign sel_b = (pwdata[0] == 1'(b));
		assign take = emit && (emit_src == (b == 0 ? rgs_pkg::SRC_USER1 : rgs_pkg::SRC_USER2));
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt <= 4'h0;
				rd <= 3'h0;
			end else if (wr && paddr == rgs_pkg::OFS_UDG_CTRL && sel_b && pwdata[1]) begin
				cnt <= 4'h0;
				rd <= 3'h0;
			end else begin
				if (wr && paddr == rgs_pkg::OFS_UDG_CD && grp_sel == 1'(b) && cnt < 4'(rgs_pkg::UDG_DEPTH)) begin
					cnt <= cnt + 4'h1;
				end
				if (take) begin
					rd <= (4'(rd) + 4'h1 >= cnt) ? 3'h0 : rd + 3'h1;
				end
			end
		end
		// storage carries no reset; count gates every read
		always_ff @(posedge pclk) begin
			if (wr && paddr == rgs_pkg::OFS_UDG_CD && grp_sel == 1'(b) && cnt < 4'(rgs_pkg::UDG_DEPTH)) begin
				mem[cnt[2:0]] <= {grp_b, pwdata};
			end
		end
		assign udg_cnt[b] = cnt;
		assign udg_head[b] = mem[rd];
		udg_cap_a: assert property (@(posedge pclk) disable iff (!presetn) cnt <= 4'(rgs_pkg::UDG_DEPTH))
			else $error("user buffer count beyond depth");
	end

	// buffer selected for pushes, held from the last control write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grp_sel <= 1'b0;
		end else if (wr && paddr == rgs_pkg::OFS_UDG_CTRL) begin
			grp_sel <= pwdata[0];
		end
	end

	// tagging: toggle, enable and running bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag <= '0;
			tag_toggle <= 1'b0;
			tag_en <= 1'b0;
			tag_run <= 1'b0;
		end else if (wr && paddr == rgs_pkg::OFS_TAG) begin
			tag <= pwdata[28:0];
			tag_toggle <= ~tag_toggle;
			tag_en <= 1'b1;
			tag_run <= 1'b1;
		end else if (wr && paddr == rgs_pkg::OFS_TAG_RUN) begin
			if (pwdata[1:0] == 2'h0) begin
				tag_run <= 1'b0;
			end else if (pwdata[1:0] == 2'h1) begin
				tag_run <= 1'b1;
			end else if (pwdata[1:0] == 2'h2) begin
				tag_en <= 1'b0;
			end
		end
	end
	// both types zero hold the bit low without losing the setting
	assign tag_running = tag_run & tag_en & ((tag.type1 != 5'h00) | (tag.type2 != 5'h00));

	// program set selection and store protection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_sel <= rgs_pkg::RST_PROGRAM;
			active_set <= rgs_pkg::RST_PROGRAM;
			nvm_load <= 1'b0;
			nvm_store <= 1'b0;
			nvm_set <= rgs_pkg::RST_PROGRAM;
			store_refused <= 1'b0;
		end else begin
			nvm_load <= 1'b0;
			nvm_store <= 1'b0;
			if (wr && paddr == rgs_pkg::OFS_PROGRAM && pwdata[1:0] != 2'h3) begin
				prog_sel <= pwdata[1:0];
				active_set <= (pwdata[1:0] == 2'h0) ? (sw_sync[1] ? 2'h1 : 2'h2) : pwdata[1:0];
				nvm_set <= (pwdata[1:0] == 2'h0) ? (sw_sync[1] ? 2'h1 : 2'h2) : pwdata[1:0];
				nvm_load <= 1'b1;
			end else if (prog_sel == 2'h0 && active_set != (sw_sync[1] ? 2'h1 : 2'h2)) begin
				active_set <= sw_sync[1] ? 2'h1 : 2'h2;
				nvm_set <= sw_sync[1] ? 2'h1 : 2'h2;
				nvm_load <= 1'b1;
			end else if (wr && paddr == rgs_pkg::OFS_STORE && prog_sel != 2'h0) begin
				nvm_store <= 1'b1;
				nvm_set <= prog_sel;
			end
			// refusal kept apart so a switch reload in the same cycle cannot swallow it
			if (wr && paddr == rgs_pkg::OFS_STORE && prog_sel == 2'h0) begin
				store_refused <= 1'b1;
			end else if (wr && paddr == rgs_pkg::OFS_STATUS && pwdata[3]) begin
				store_refused <= 1'b0;
			end
		end
	end

	// short text termination flag per new text length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rt_update <= 1'b0;
			rt_cr_insert <= 1'b0;
		end else begin
			rt_update <= wr && paddr == rgs_pkg::OFS_RT_LEN;
			if (wr && paddr == rgs_pkg::OFS_RT_LEN) begin
				rt_cr_insert <= ctrl[4] && (pwdata[7:0] < rgs_pkg::SHORT_TEXT_LIMIT);
			end
		end
	end

	list_ptr_a: assert property (@(posedge pclk) disable iff (!presetn) ptr < list_len)
		else $error("list pointer outside list");
	tick_emit_a: assert property (@(posedge pclk) disable iff (!presetn) tick |-> ##[1:27] group_valid)
		else $error("group period without a group");
	direct_first_a: assert property (@(posedge pclk) disable iff (!presetn)
		tick && state == rgs_pkg::ST_IDLE && direct_pend |=> group_valid && group_out.src == rgs_pkg::SRC_DIRECT)
		else $error("injected group not sent first");
	proto_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
		tick && state == rgs_pkg::ST_IDLE && !direct_pend && !ct_pend && proto_pend && !u_listed
		|=> group_valid && group_out.src == rgs_pkg::SRC_PROTO)
		else $error("protocol group not sent at once");
	toggle_flip_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == rgs_pkg::OFS_TAG |=> tag_toggle != $past(tag_toggle))
		else $error("toggle bit not inverted");
	tag_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == rgs_pkg::OFS_TAG_RUN && pwdata[1:0] == 2'h2 |=> !tag_en && !tag_running)
		else $error("tagging not disabled");
	store_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == rgs_pkg::OFS_STORE && prog_sel == 2'h0 |=> !nvm_store && store_refused)
		else $error("store allowed with undefined set");
	pi_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		group_valid |-> group_out.blk_a == $past(pi))
		else $error("block 1 differs from programme code");
	rtp_listed_a: assert property (@(posedge pclk) disable iff (!presetn)
		group_valid && (group_out.src == rgs_pkg::SRC_3A || group_out.src == rgs_pkg::SRC_11A) |-> $past(tag_en))
		else $error("tagging group while tagging off");
endmodule : rgs_scheduler

// ===== bench/rgs_host.sv
// apb host model issuing configuration commands
`timescale 1ns/10ps
module rgs_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end
	// one whole transfer, held until pready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // released data must not look valid
	endtask : xfer
endmodule : rgs_host

// ===== bench/rgs_scheduler_tb.sv
// self-checking bench of the group sequence scheduler
`timescale 1ns/10ps
module rgs_scheduler_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, group_valid, tag_toggle, tag_running;
	logic nvm_load, nvm_store, rt_update, rt_cr_insert, sw, ct;
	logic [1:0] active_set, nvm_set;
	logic [15:0] b_seen;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	rgs_pkg::rgs_group_s group_out;
	int err_count, compares;
	// address beside expected reset read value
	logic [39:0] rows [4] = '{{8'h00, 32'h0F}, {8'h04, 32'h00}, {8'h30, 32'h05}, {8'h40, 32'h00}};
	// short group period keeps the run brief
	rgs_scheduler #(.GROUP_PERIOD(64)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_program_sel(sw), .ct_request(ct), .group_out(group_out), .group_valid(group_valid),
		.tag_toggle(tag_toggle), .tag_running(tag_running), .active_set(active_set), .nvm_load(nvm_load),
		.nvm_store(nvm_store), .nvm_set(nvm_set), .rt_update(rt_update), .rt_cr_insert(rt_cr_insert));
	rgs_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		i_host.xfer(1'b0, a, 32'h0, q);
	endtask : rd
	// begin, append k ascii symbols (first symbol leftmost), commit
	task automatic list(input logic [23:0] s, input int k);
		wr(8'h0C, 32'h1);
		for (int i = 0; i < k; i++) wr(8'h08, {24'h0, s[8*(k-1-i)+:8]});
		wr(8'h0C, 32'h2);
	endtask : list
	// next group must come within 100 cycles and, when chk is set, carry source e
	task automatic grp(input logic [3:0] e, input bit chk);
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (group_valid !== 1'b1 && n < 300);
		check({31'h0, n < 100}, 32'h1);
		if (chk) check({28'h0, group_out.src}, {28'h0, e});
	endtask : grp
	// a group already under way may come first; source e within three groups
	task automatic find(input logic [3:0] e);
		int i;
		i = 0;
		do begin
			grp(e, 1'b0);
			i++;
		end while (group_out.src !== e && i < 3);
		check({28'h0, group_out.src}, {28'h0, e});
	endtask : find
	// user group payload must be the one pushed beside its block 2
	task automatic ucheck();
		check({16'h0, group_out.blk_a}, 32'h1234);
		check({group_out.blk_c, group_out.blk_d}, group_out.blk_b == 16'hABCD ? 32'h11112222 : 32'h33334444);
	endtask : ucheck
	task automatic summarize();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// hang guard well beyond the expected run
	initial begin
		#(50 * 8000);
		err_count++;
		summarize();
	end
	initial begin
		presetn = 1'b0;
		sw = 1'b1;
		ct = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i][39:32]);
			check(q, rows[i][31:0]);
		end
		// unknown symbol drops itself and what follows
		list("0Z2", 3);
		rd(8'h10);
		check({27'h0, q[4:0]}, 32'h1);
		repeat (4) grp(4'h0, 1'b0);
		repeat (4) grp(rgs_pkg::SRC_0A, 1'b1);
		// two groups into buffer one while 'X' is unlisted, then 'X' alone
		wr(8'h04, 32'h1234);
		wr(8'h14, 32'h2);
		wr(8'h18, 32'hABCD);
		wr(8'h1C, 32'h11112222);
		wr(8'h18, 32'h5555);
		wr(8'h1C, 32'h33334444);
		rd(8'h38);
		check({28'h0, q[7:4]}, 32'h2);
		list("X", 1);
		find(rgs_pkg::SRC_USER1);
		ucheck();
		b_seen = group_out.blk_b;
		grp(rgs_pkg::SRC_USER1, 1'b1);
		ucheck();
		check({16'h0, group_out.blk_b ^ b_seen}, 32'hFE98);
		// injected, clock-time and protocol groups ignore the list
		wr(8'h18, 32'h0BAD);
		wr(8'h24, 32'h1);
		find(rgs_pkg::SRC_DIRECT);
		check({16'h0, group_out.blk_b}, 32'h0BAD);
		@(posedge pclk);
		ct <= 1'b1;
		repeat (4) @(posedge pclk);
		ct <= 1'b0;
		find(rgs_pkg::SRC_4A);
		wr(8'h20, 32'h2);
		find(rgs_pkg::SRC_PROTO);
		// a cleared buffer leaves only the fallback group
		wr(8'h14, 32'h2);
		rd(8'h38);
		check({28'h0, q[7:4]}, 32'h0);
		grp(4'h0, 1'b0);
		grp(rgs_pkg::SRC_0A, 1'b1);
		list("Z", 1);
		rd(8'h10);
		check({27'h0, q[4:0]}, 32'h1);
		// 2A disabled and 0 absent: only 1A wraps round
		wr(8'h00, 32'h01);
		list("12", 2);
		repeat (4) grp(4'h0, 1'b0);
		repeat (4) grp(rgs_pkg::SRC_1A, 1'b1);
		list(24'h0, 0);
		rd(8'h10);
		check({27'h0, q[4:0]}, 32'h10);
		wr(8'h28, 32'h04000000);
		rd(8'h28);
		check(q, 32'h04000000);
		rd(8'h38);
		check({29'h0, q[2:0]}, 32'h7);
		wr(8'h2C, 32'h0);
		rd(8'h38);
		check({31'h0, tag_running}, 32'h0);
		// both types zero keeps running low, toggle flips back
		wr(8'h28, 32'h0);
		rd(8'h38);
		check({29'h0, q[2:0]}, 32'h4);
		check({31'h0, tag_toggle}, 32'h0);
		// radiotext-plus goes out as alternating 3A and 11A
		list("R", 1);
		find(rgs_pkg::SRC_3A);
		grp(rgs_pkg::SRC_11A, 1'b1);
		wr(8'h2C, 32'h2);
		rd(8'h38);
		check({29'h0, q[2:0]}, 32'h0);
		grp(4'h0, 1'b0);
		grp(rgs_pkg::SRC_0A, 1'b1);
		// short text flag follows the length of each new text
		wr(8'h00, 32'h1F);
		wr(8'h3C, 32'h3B);
		@(negedge pclk);
		check({30'h0, rt_update, rt_cr_insert}, 32'h3);
		wr(8'h3C, 32'h3C);
		@(negedge pclk);
		check({30'h0, rt_update, rt_cr_insert}, 32'h2);
		// set two loads and stores; selector zero follows the pin and refuses stores
		wr(8'h30, 32'h2);
		@(negedge pclk);
		check({27'h0, nvm_load, nvm_set, active_set}, 32'h1A);
		wr(8'h34, 32'h0);
		@(negedge pclk);
		check({29'h0, nvm_store, nvm_set}, 32'h6);
		wr(8'h30, 32'h0);
		@(negedge pclk);
		check({30'h0, active_set}, 32'h1);
		@(posedge pclk);
		sw <= 1'b0;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		check({30'h0, active_set}, 32'h2);
		wr(8'h34, 32'h0);
		@(negedge pclk);
		check({31'h0, nvm_store}, 32'h0);
		rd(8'h38);
		check({31'h0, q[3]}, 32'h1);
		summarize();
	end
endmodule : rgs_scheduler_tb
